/* logic/ahp_map.svh */
// Purpose: Address map, field positions and reset values of the host port
// Assumes: Included by the host port design file and the testbench
// Notes:   Definitions only
`ifndef AHP_MAP_SVH
`define AHP_MAP_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define AHP_A_GMASK     13'h0000
`define AHP_A_FR_STAT   13'h0001
`define AHP_A_FR_MASK   13'h0002
`define AHP_A_LIU_STAT  13'h0003
`define AHP_A_LIU_MASK  13'h0004
`define AHP_A_BERT_STAT 13'h0005
`define AHP_A_BERT_MASK 13'h0006
`define AHP_A_CLK_CFG   13'h0007
`define AHP_A_SCRATCH   13'h0008

// ------------------------------------------------------------
// Groups, fields and reset values
// ------------------------------------------------------------
`define AHP_GRP_FR      2'h0
`define AHP_GRP_LIU     2'h1
`define AHP_GRP_BERT    2'h2
`define AHP_NUM_GRP     3
`define AHP_CFG_MCLK_MULTIPLIER_SEL_0    0
`define AHP_CFG_MCLK_MULTIPLIER_SEL_1    1
`define AHP_CFG_BASE    2
`define AHP_BYTE_RST    8'h00
`define AHP_BYTE_NONE   8'h00
`define AHP_ADDR_RST    13'h0000

`endif

/* logic/ahp_pkg.sv */
// Purpose: Types shared by the host port design
// Assumes: Nothing
// Notes:   Constants live in ahp_map.svh
package ahp_pkg;

    typedef struct packed {
        logic chip_select_n;
        logic read_or_data_strobe_n;
        logic write_or_direction_n;
    } ahp_strobe_type;

    typedef struct packed {
        logic [7:0] framer;
        logic [7:0] liu;
        logic [7:0] bert;
    } ahp_event_type;

    typedef struct packed {
        logic       stat;
        logic       mask;
        logic [1:0] grp;
    } ahp_dec_type;

    typedef enum logic [1:0] {
        AHP_IDLE  = 2'h0,
        AHP_WRITE = 2'h1
    } ahp_state_type;

    typedef enum logic [1:0] {
        AHP_ADAPT_NONE = 2'h0,
        AHP_ADAPT_DOWN = 2'h1,
        AHP_ADAPT_UP   = 2'h3
    } ahp_adapt_type;

endpackage

/* logic/ahp_host_port.sv */
// Purpose: Eight-bit parallel register port with interrupt and clock config
// Assumes: All pins synchronous to core_clk; srst synchronous active high
// Notes:   Status registers are write-one-to-clear; new events win over clears
`timescale 1ns/100ps
`include "ahp_map.svh"

// What this block does
// - Eight-bit data bus, bit 7 most significant
// - Chip select low qualifies every strobe
// - Drive read data while read and select low
// - Write captured at write strobe rising edge
// - Unmasked pending event pulls interrupt low
// - Interrupt released once all sources cleared
// - Global and per-group masks block events
// - Bus style pin picks strobe timing
// - Multiplier and base-rate bits name master clock
// - Adapt master clock rate between line rates
module ahp_host_port (
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    input  wire logic                    clk_en,
    input  wire logic [12:0]             reg_addr,
    input  wire logic [7:0]              data_in,
    output logic      [7:0]              data_out,
    output logic                         data_oe,
    input  wire ahp_pkg::ahp_strobe_type strobe,
    input  wire logic                    bus_style_select,
    input  wire ahp_pkg::ahp_event_type  events,
    input  wire logic                    line_mode_e1,
    output logic                         irq_out_n_o,
    output logic                         irq_out_n_oe,
    output logic                         mclk_multiplier_sel_0,
    output logic                         mclk_multiplier_sel_1,
    output logic                         base_rate_select,
    output ahp_pkg::ahp_adapt_type       rate_adapt
);

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    function automatic ahp_pkg::ahp_dec_type ahp_decode(input logic [12:0] a);
        ahp_pkg::ahp_dec_type d;
        d = '0;
        if (a == `AHP_A_FR_STAT)
        begin
            d.stat = 1'b1;
            d.grp  = `AHP_GRP_FR;
        end
        else if (a == `AHP_A_FR_MASK)
        begin
            d.mask = 1'b1;
            d.grp  = `AHP_GRP_FR;
        end
        else if (a == `AHP_A_LIU_STAT)
        begin
            d.stat = 1'b1;
            d.grp  = `AHP_GRP_LIU;
        end
        else if (a == `AHP_A_LIU_MASK)
        begin
            d.mask = 1'b1;
            d.grp  = `AHP_GRP_LIU;
        end
        else if (a == `AHP_A_BERT_STAT)
        begin
            d.stat = 1'b1;
            d.grp  = `AHP_GRP_BERT;
        end
        else if (a == `AHP_A_BERT_MASK)
        begin
            d.mask = 1'b1;
            d.grp  = `AHP_GRP_BERT;
        end
        return d;
    endfunction

    // ------------------------------------------------------------
    // Strobe interpretation
    // ------------------------------------------------------------
    logic                   selected;
    logic                   strobe_low;
    logic                   dir_read;
    logic                   rd_req;
    logic                   wr_low;
    logic                   commit;
    ahp_pkg::ahp_state_type state;
    ahp_pkg::ahp_state_type next_state;
    logic [12:0]            addr_q;
    logic [7:0]             data_q;

    assign selected   = ~strobe.chip_select_n;
    assign strobe_low = ~strobe.read_or_data_strobe_n;
    assign dir_read   = strobe.write_or_direction_n;
    assign rd_req = bus_style_select ? (selected & strobe_low & dir_read) : (selected & strobe_low);
    assign wr_low = bus_style_select ? (selected & strobe_low & ~dir_read)
                                     : (selected & ~strobe.write_or_direction_n);
    assign commit = (state == ahp_pkg::AHP_WRITE) & selected & ~wr_low;

    always_comb
    begin
        next_state = state;
        case (state)
            ahp_pkg::AHP_IDLE:
                if (wr_low)
                    next_state = ahp_pkg::AHP_WRITE;
            ahp_pkg::AHP_WRITE:
                if (!wr_low)
                    next_state = ahp_pkg::AHP_IDLE;
            default:
                next_state = ahp_pkg::AHP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            state <= ahp_pkg::AHP_IDLE;
        else if (clk_en)
            state <= next_state;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            addr_q <= `AHP_ADDR_RST;
            data_q <= `AHP_BYTE_RST;
        end
        else if (clk_en && wr_low)
        begin
            addr_q <= reg_addr;
            data_q <= data_in;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    ahp_pkg::ahp_dec_type   wr_dec;
    ahp_pkg::ahp_dec_type   rd_dec;
    logic [7:0]             gmask;
    logic [7:0]             clk_cfg;
    logic [7:0]             scratch;
    logic [7:0]             stat [`AHP_NUM_GRP];
    logic [7:0]             mask [`AHP_NUM_GRP];
    logic [7:0]             evt  [`AHP_NUM_GRP];
    logic [`AHP_NUM_GRP-1:0] grp_irq;

    assign wr_dec = ahp_decode(addr_q);
    assign rd_dec = ahp_decode(reg_addr);
    assign evt[`AHP_GRP_FR]   = events.framer;
    assign evt[`AHP_GRP_LIU]  = events.liu;
    assign evt[`AHP_GRP_BERT] = events.bert;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            gmask   <= `AHP_BYTE_RST;
            clk_cfg <= `AHP_BYTE_RST;
            scratch <= `AHP_BYTE_RST;
        end
        else if (clk_en && commit)
        begin
            if (addr_q == `AHP_A_GMASK)
                gmask <= data_q;
            if (addr_q == `AHP_A_CLK_CFG)
                clk_cfg <= data_q;
            if (addr_q == `AHP_A_SCRATCH)
                scratch <= data_q;
        end
    end

    generate
        for (genvar g = 0; g < `AHP_NUM_GRP; g++)
        begin : g_grp
            logic [7:0] clr;
            logic [7:0] next_stat;
            assign clr       = (commit && wr_dec.stat && wr_dec.grp == 2'(g)) ? data_q : `AHP_BYTE_NONE;
            assign next_stat = (stat[g] & ~clr) | evt[g];
            assign grp_irq[g] = gmask[g] & (|(stat[g] & mask[g]));
            always_ff @(posedge core_clk)
            begin
                if (srst)
                begin
                    stat[g] <= `AHP_BYTE_RST;
                    mask[g] <= `AHP_BYTE_RST;
                end
                else if (clk_en)
                begin
                    stat[g] <= next_stat;
                    if (commit && wr_dec.mask && wr_dec.grp == 2'(g))
                        mask[g] <= data_q;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path and interrupt
    // ------------------------------------------------------------
    logic [7:0]             rd_mux;
    ahp_pkg::ahp_adapt_type next_adapt;

    assign rd_mux = rd_dec.stat                  ? stat[rd_dec.grp] :
                    rd_dec.mask                  ? mask[rd_dec.grp] :
                    (reg_addr == `AHP_A_GMASK)   ? gmask :
                    (reg_addr == `AHP_A_CLK_CFG) ? clk_cfg :
                    (reg_addr == `AHP_A_SCRATCH) ? scratch : `AHP_BYTE_NONE;

    always_ff @(posedge core_clk)
    begin
        if (srst)
            data_out <= `AHP_BYTE_RST;
        else if (clk_en)
            data_out <= rd_mux;
    end

    assign data_oe = rd_req;

    assign irq_out_n_o  = 1'b0;
    assign irq_out_n_oe = |grp_irq;

    // ------------------------------------------------------------
    // Master clock configuration
    // ------------------------------------------------------------
    // adapt base rate to line
    assign next_adapt = ( clk_cfg[`AHP_CFG_BASE] && !line_mode_e1) ? ahp_pkg::AHP_ADAPT_DOWN :
                        (!clk_cfg[`AHP_CFG_BASE] &&  line_mode_e1) ? ahp_pkg::AHP_ADAPT_UP :
                        ahp_pkg::AHP_ADAPT_NONE;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            mclk_multiplier_sel_0 <= 1'b0;
            mclk_multiplier_sel_1 <= 1'b0;
            base_rate_select      <= 1'b0;
            rate_adapt            <= ahp_pkg::AHP_ADAPT_NONE;
        end
        else if (clk_en)
        begin
            mclk_multiplier_sel_0 <= clk_cfg[`AHP_CFG_MCLK_MULTIPLIER_SEL_0];
            mclk_multiplier_sel_1 <= clk_cfg[`AHP_CFG_MCLK_MULTIPLIER_SEL_1];
            base_rate_select      <= clk_cfg[`AHP_CFG_BASE];
            rate_adapt            <= next_adapt;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_select_gates_bus: assert property (strobe.chip_select_n |-> !data_oe && !commit)
        else $error("bus active without chip select");
    a_read_drive: assert property (!bus_style_select && selected && strobe_low |-> data_oe)
        else $error("separate read not driven");
    a_write_capture: assert property (clk_en && commit && addr_q == `AHP_A_SCRATCH |=> scratch == $past(data_q))
        else $error("write strobe rise did not store");
    a_irq_pending: assert property (gmask[0] && |(stat[0] & mask[0]) |-> irq_out_n_oe && !irq_out_n_o)
        else $error("unmasked event not signalled");
    a_irq_release: assert property (stat[0] == 8'h00 && stat[1] == 8'h00 && stat[2] == 8'h00 |-> !irq_out_n_oe)
        else $error("interrupt held with nothing pending");
    a_mask_blocks: assert property (gmask[2:0] == 3'h0 |-> !irq_out_n_oe)
        else $error("masked event reached interrupt");
    a_ds_direction: assert property (bus_style_select && selected && strobe_low |-> data_oe == dir_read)
        else $error("direction pin misread");
    a_event_wins: assert property (clk_en && evt[0][0] |=> stat[0][0])
        else $error("event lost against clear");
    a_cfg_pins: assert property (clk_en && commit && addr_q == `AHP_A_CLK_CFG ##1 clk_en |=>
        mclk_multiplier_sel_1 == $past(data_q[`AHP_CFG_MCLK_MULTIPLIER_SEL_1], 2))
        else $error("clock select pins not updated");
    a_rate_adapt: assert property (clk_en && clk_cfg[`AHP_CFG_BASE] && !line_mode_e1 |=>
        rate_adapt == ahp_pkg::AHP_ADAPT_DOWN)
        else $error("rate adaptation wrong");
    a_style_write: assert property (clk_en && !bus_style_select && selected &&
        !strobe.write_or_direction_n |=> state == ahp_pkg::AHP_WRITE)
        else $error("separate write strobe not taken");

    c_sep_write: cover property (!bus_style_select && commit);
    c_ds_read: cover property (bus_style_select && data_oe);
    c_irq_cycle: cover property (irq_out_n_oe ##[1:20] !irq_out_n_oe);
    c_ds_write: cover property (bus_style_select && commit);
    c_frozen_write: cover property (!clk_en && wr_low);

endmodule // ahp_host_port

/* tb/ahp_host_model.sv */
// Purpose: Host processor model driving the parallel register port
// Assumes: Pins change just after core_clk rising edges
// Notes:   Released write data shows the inverse of the last value
`timescale 1ns/100ps

module ahp_host_model (
    input  wire logic               core_clk,
    input  wire logic               bus_style_select,
    input  wire logic [7:0]         data_out,
    input  wire logic               data_oe,
    output ahp_pkg::ahp_strobe_type strobe,
    output logic      [12:0]        reg_addr,
    output logic      [7:0]         data_in
);
    initial
    begin
        strobe   = 3'h7;
        reg_addr = 13'h0000;
        data_in  = 8'h00;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // address, select, strobe framing
    task automatic host_write(input logic [12:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr                     <= a;
        data_in                      <= d;
        strobe.chip_select_n         <= 1'b0;
        strobe.read_or_data_strobe_n <= ~bus_style_select;
        strobe.write_or_direction_n  <= 1'b0;
        @(posedge core_clk);
        strobe.read_or_data_strobe_n <= 1'b1;
        strobe.write_or_direction_n  <= ~bus_style_select;
        @(posedge core_clk);
        strobe                       <= 3'h7;
        data_in                      <= ~d;
    endtask

    // read framed by select and strobe
    task automatic host_read(input logic [12:0] a, output logic [7:0] d, output logic oe);
        @(posedge core_clk);
        reg_addr                     <= a;
        strobe.chip_select_n         <= 1'b0;
        strobe.read_or_data_strobe_n <= 1'b0;
        strobe.write_or_direction_n  <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        d  = data_out;
        oe = data_oe;
        @(posedge core_clk);
        strobe                       <= 3'h7;
    endtask

    task automatic host_stray(input logic [12:0] a, input logic [7:0] d, output logic oe);
        @(posedge core_clk);
        reg_addr                     <= a;
        data_in                      <= d;
        strobe.read_or_data_strobe_n <= 1'b0;
        strobe.write_or_direction_n  <= 1'b0;
        @(posedge core_clk);
        #1;
        oe = data_oe;
        @(posedge core_clk);
        strobe                       <= 3'h7;
        data_in                      <= ~d;
    endtask
endmodule // ahp_host_model

/* tb/testbench.sv */
// Purpose: Self-checking bench for the parallel host port
// Assumes: Host model performs every bus cycle
// Notes:   Interrupt pin resolved with a pull-up
`timescale 1ns/100ps
`include "ahp_map.svh"

module testbench;
    logic                    core_clk;
    logic                    srst             = 1'b1;
    logic                    bus_style_select = 1'b0;
    logic                    line_mode_e1     = 1'b0;
    logic                    clk_en           = 1'b1;
    ahp_pkg::ahp_event_type  events           = '0;
    ahp_pkg::ahp_strobe_type strobe;
    logic [12:0]             reg_addr;
    logic [7:0]              data_in;
    logic [7:0]              data_out;
    logic                    data_oe;
    logic                    irq_out_n_o;
    logic                    irq_out_n_oe;
    logic                    mclk_multiplier_sel_0;
    logic                    mclk_multiplier_sel_1;
    logic                    base_rate_select;
    ahp_pkg::ahp_adapt_type  rate_adapt;
    logic [7:0]              rdata;
    logic                    oe;
    int                      mismatches       = 0;
    int                      n_checks         = 0;
    int                      cycles           = 0;
    logic [7:0]              cfg_val [4]      = '{8'h07, 8'h00, 8'h04, 8'h03};
    logic                    cfg_e1 [4]       = '{1'b0, 1'b1, 1'b1, 1'b0};
    ahp_pkg::ahp_adapt_type  cfg_adapt [4]    = '{ahp_pkg::AHP_ADAPT_DOWN, ahp_pkg::AHP_ADAPT_UP,
                                                  ahp_pkg::AHP_ADAPT_NONE, ahp_pkg::AHP_ADAPT_NONE};
    wire logic               irq_pin          = irq_out_n_oe ? irq_out_n_o : 1'b1;
    wire logic [7:0]         cfg_out          = {5'h00, base_rate_select, mclk_multiplier_sel_1,
                                                 mclk_multiplier_sel_0};

    ahp_host_port DUT (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .strobe(strobe),
        .bus_style_select(bus_style_select), .events(events), .line_mode_e1(line_mode_e1),
        .irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe), .rate_adapt(rate_adapt),
        .mclk_multiplier_sel_0(mclk_multiplier_sel_0), .mclk_multiplier_sel_1(mclk_multiplier_sel_1),
        .base_rate_select(base_rate_select));

    ahp_host_model HOST (.core_clk(core_clk), .bus_style_select(bus_style_select), .data_out(data_out),
        .data_oe(data_oe), .strobe(strobe), .reg_addr(reg_addr), .data_in(data_in));

    // ------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------
    // free-running master clock
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        HOST.host_read(a, rdata, oe);
        chk(exp, rdata);
        chk(8'h01, {7'h00, oe});
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1 chk(8'h00, cfg_out);
        chk(8'h01, {7'h00, irq_pin});
        for (int m = 0; m < 2; m++)
        begin
            @(posedge core_clk);
            bus_style_select <= m[0];
            HOST.host_write(`AHP_A_SCRATCH, 8'hA5 ^ {8{m[0]}});
            rd_chk(`AHP_A_SCRATCH, 8'hA5 ^ {8{m[0]}});
            HOST.host_stray(`AHP_A_SCRATCH, 8'h3C, oe);
            chk(8'h00, {7'h00, oe});
            rd_chk(`AHP_A_SCRATCH, 8'hA5 ^ {8{m[0]}});
            rd_chk(13'h1FFF, 8'h00);
        end
        bus_style_select <= 1'b0;
        clk_en           <= 1'b0;
        HOST.host_write(`AHP_A_SCRATCH, 8'hC3);
        clk_en           <= 1'b1;
        rd_chk(`AHP_A_SCRATCH, 8'h5A);
        for (int g = 0; g < 3; g++)
        begin
            @(posedge core_clk);
            events <= ahp_pkg::ahp_event_type'(24'h000001 << (8 * (2 - g)));
            @(posedge core_clk);
            events <= '0;
            HOST.host_write(13'(2 + 2 * g), 8'h01);
            repeat (2) @(posedge core_clk);
            #1 chk(8'h01, {7'h00, irq_pin});
            HOST.host_write(`AHP_A_GMASK, 8'(1 << g));
            repeat (2) @(posedge core_clk);
            #1 chk(8'h00, {7'h00, irq_pin});
            rd_chk(13'(1 + 2 * g), 8'h01);
            HOST.host_write(13'(1 + 2 * g), 8'h01);
            repeat (2) @(posedge core_clk);
            #1 chk(8'h01, {7'h00, irq_pin});
        end
        for (int i = 0; i < 4; i++)
        begin
            HOST.host_write(`AHP_A_CLK_CFG, cfg_val[i]);
            line_mode_e1 <= cfg_e1[i];
            repeat (2) @(posedge core_clk);
            #1 chk(cfg_val[i], cfg_out);
            chk({6'h00, cfg_adapt[i]}, {6'h00, rate_adapt});
        end
        test_done();
    end
endmodule // testbench
